// ===== hdl/pin_output_mux.v
// Purpose: output-source multiplexer and control registers for two general-purpose pins
// Assumes: lock, pass and forwarded pin inputs come from other clock domains or pins
// Notes:
// Notes on behaviour
// RULE1: pin 2 source code 000 port 0, 001 port 1, 100 device status.
// RULE2: port source, secondary 000..011 gives forwarded remote pin 0..3.
// RULE3: port source, secondary 100 gives lock flag, 101 pass flag.
// RULE4: status source, secondary 000 gives pin 2 local value.
// RULE5: status 001 OR of locks, 010 AND of locks, 011 AND of passes.
// RULE6: status source, secondary 100 gives the frame-sync signal.
// RULE7: local value bit 1 sets level for register-controlled output.
// RULE8: enable bit 0 turns the pin 2 driver off at 0, on at 1.
// RULE9: pin 1 source codes match pin 2.
// RULE10: pin 1 local value bit 1 sets its register-controlled level.
// RULE11: pin 1 enable bit 0 turns its driver off or on.
// RULE12: pin 1 secondary select bits 7:5 decode as pin 2.
// RULE13: reserved source or secondary codes drive constant low.
// RULE14: both control registers reset to zero, outputs disabled.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "pin_mux_regs.vh"
module pin_output_mux (
    input wire CLK,
    input wire RST_N,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    input wire [1:0] PORT_ENABLE,
    input wire [1:0] PORT_LOCK,
    input wire [1:0] PORT_PASS,
    input wire [3:0] PORT0_REMOTE_PIN,
    input wire [3:0] PORT1_REMOTE_PIN,
    input wire FRAME_SYNC_SIGNAL,
    output reg PIN1_OUT,
    output reg PIN1_OE_N,
    output reg PIN2_OUT,
    output reg PIN2_OE_N
);
    reg [7:0] pin1_ctrl_q;
    reg [7:0] pin2_ctrl_q;
    reg [14:0] sync1_q;
    reg [14:0] sync2_q;
    reg pin1_d;
    reg pin2_d;
    wire [1:0] en_w;
    wire [1:0] lock_w;
    wire [1:0] pass_w;
    wire [3:0] rp0_w;
    wire [3:0] rp1_w;
    wire fsync_w;
    wire any_lock_w;
    wire all_lock_w;
    wire all_pass_w;

    // two-stage synchronisers; only the second stage feeds the mux
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 15'h0000;
            sync2_q <= 15'h0000;
        end else begin
            sync1_q <= {PORT_ENABLE, PORT_LOCK, PORT_PASS, PORT0_REMOTE_PIN,
                        PORT1_REMOTE_PIN, FRAME_SYNC_SIGNAL};
            sync2_q <= sync1_q;
        end
    end
    assign en_w = sync2_q[14:13];
    assign lock_w = sync2_q[12:11];
    assign pass_w = sync2_q[10:9];
    assign rp0_w = sync2_q[8:5];
    assign rp1_w = sync2_q[4:1];
    assign fsync_w = sync2_q[0];

    // combined conditions over enabled ports; with none enabled the ANDs read low
    // RULE5: combined lock/pass
    assign any_lock_w = |(lock_w & en_w);
    assign all_lock_w = (|en_w) & (&(lock_w | ~en_w));
    assign all_pass_w = (|en_w) & (&(pass_w | ~en_w));

    // register writes
    // RULE14: reset to zero
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin1_ctrl_q <= `CTRL_RESET;
            pin2_ctrl_q <= `CTRL_RESET;
        end else if (WR) begin
            if (ADDR == `PIN1_CTRL_ADDR) begin
                pin1_ctrl_q <= WDATA;
            end
            if (ADDR == `PIN2_CTRL_ADDR) begin
                pin2_ctrl_q <= WDATA;
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped addresses
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (RD && ADDR == `PIN1_CTRL_ADDR) begin
            RDATA <= pin1_ctrl_q;
        end else if (RD && ADDR == `PIN2_CTRL_ADDR) begin
            RDATA <= pin2_ctrl_q;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // one selector shared by both pins, since the encodings are identical
    function sel_level;
        input [7:0] ctrl;
        input [3:0] r0;
        input [3:0] r1;
        input [1:0] lk;
        input [1:0] ps;
        input any_l;
        input all_l;
        input all_p;
        input fs;
        reg [2:0] src;
        reg [2:0] sec;
        reg [3:0] rp;
        reg idx;
        begin
            src = ctrl[`SRC_MSB:`SRC_LSB];
            sec = ctrl[`SEC_MSB:`SEC_LSB];
            idx = src[0];
            rp = idx ? r1 : r0;
            sel_level = 1'b0;
            // RULE1: source decode
            // RULE9: pin 1 source
            if (src == `SRC_PORT0 || src == `SRC_PORT1) begin
                // RULE2: forwarded pins
                if (sec[2] == 1'b0) begin
                    sel_level = rp[sec[1:0]];
                // RULE3: lock and pass
                end else if (sec == `SEC_LOCK) begin
                    sel_level = lk[idx];
                end else if (sec == `SEC_PASS) begin
                    sel_level = ps[idx];
                end
            end else if (src == `SRC_STATUS) begin
                case (sec)
                    // RULE4: local value
                    // RULE7: register level
                    // RULE10: pin 1 level
                    `SEC_LOCAL: sel_level = ctrl[`VAL_BIT];
                    `SEC_ANY_LOCK: sel_level = any_l;
                    `SEC_ALL_LOCK: sel_level = all_l;
                    `SEC_ALL_PASS: sel_level = all_p;
                    // RULE6: frame sync
                    `SEC_FSYNC: sel_level = fs;
                    // RULE13: reserved low
                    default: sel_level = 1'b0;
                endcase
            end
        end
    endfunction

    // RULE12: pin 1 secondary
    always @* begin
        pin1_d = sel_level(pin1_ctrl_q, rp0_w, rp1_w, lock_w, pass_w,
                           any_lock_w, all_lock_w, all_pass_w, fsync_w);
        pin2_d = sel_level(pin2_ctrl_q, rp0_w, rp1_w, lock_w, pass_w,
                           any_lock_w, all_lock_w, all_pass_w, fsync_w);
    end

    // registered pin drive; enable low means driving
    // RULE8: pin 2 driver
    // RULE11: pin 1 driver
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PIN1_OUT <= 1'b0;
            PIN2_OUT <= 1'b0;
            PIN1_OE_N <= 1'b1;
            PIN2_OE_N <= 1'b1;
        end else begin
            PIN1_OUT <= pin1_d;
            PIN2_OUT <= pin2_d;
            PIN1_OE_N <= ~pin1_ctrl_q[`EN_BIT];
            PIN2_OE_N <= ~pin2_ctrl_q[`EN_BIT];
        end
    end
endmodule

// ===== common/pin_mux_regs.vh
// Purpose: register offsets, field positions and reset values of the pin output mux
// Assumes: 8-bit registers on a plain strobe port
// Notes: byte offsets as printed
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH
`define PIN1_CTRL_ADDR 8'h11
`define PIN2_CTRL_ADDR 8'h12
`define CTRL_RESET 8'h00
`define SEC_MSB 7
`define SEC_LSB 5
`define SRC_MSB 4
`define SRC_LSB 2
`define VAL_BIT 1
`define EN_BIT 0
`define SRC_PORT0 3'h0
`define SRC_PORT1 3'h1
`define SRC_STATUS 3'h4
`define SEC_LOCK 3'h4
`define SEC_PASS 3'h5
`define SEC_LOCAL 3'h0
`define SEC_ANY_LOCK 3'h1
`define SEC_ALL_LOCK 3'h2
`define SEC_ALL_PASS 3'h3
`define SEC_FSYNC 3'h4
`endif

// ===== dv/pin_output_mux_props.sv
// Purpose: port timing checks for the pin output mux
// Assumes: one clock, async active-low reset
// Notes: input paths get four quiet cycles for the synchroniser
`timescale 1ns/10ps
module pin_output_mux_props (
    input CLK,
    input RST_N,
    input [7:0] ADDR,
    input [7:0] WDATA,
    input WR,
    input RD,
    input [7:0] RDATA,
    input [1:0] PORT_LOCK,
    input FRAME_SYNC_SIGNAL,
    input PIN1_OE_N,
    input PIN2_OUT,
    input PIN2_OE_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_rst; $rose(RST_N) |-> PIN1_OE_N && PIN2_OE_N && !PIN2_OUT; endproperty
    a_rst: assert property (p_rst) else $error("pin busy");
    property p_rd; WR && ADDR == 8'h12 ##2 RD && ADDR == 8'h12 && !$past(WR)
        |=> RDATA == $past(WDATA, 3); endproperty
    a_rd: assert property (p_rd) else $error("readback");
    // register lands at the write edge, the pin flop follows one edge later
    property p_en2; WR && ADDR == 8'h12 ##1 !WR |=> PIN2_OE_N == !$past(WDATA[0], 2); endproperty
    a_en2: assert property (p_en2) else $error("enable 2");
    property p_en1; WR && ADDR == 8'h11 ##1 !WR |=> PIN1_OE_N == !$past(WDATA[0], 2); endproperty
    a_en1: assert property (p_en1) else $error("enable 1");
    property p_val; WR && ADDR == 8'h12 && WDATA[7:2] == 6'h04
        ##1 !WR |=> PIN2_OUT == $past(WDATA[1], 2); endproperty
    a_val: assert property (p_val) else $error("local value");
    property p_rsv; WR && ADDR == 8'h12 && WDATA[4:3] == 2'h1 ##1 !WR |=> !PIN2_OUT; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    // four write-free cycles cover both sync stages and the pin flop
    property p_lck; WR && ADDR == 8'h12 && WDATA == 8'h81 ##1 (!WR && $stable(PORT_LOCK[0]))[*4]
        |-> PIN2_OUT == PORT_LOCK[0]; endproperty
    a_lck: assert property (p_lck) else $error("lock");
    property p_fs; WR && ADDR == 8'h12 && WDATA == 8'h91 ##1 (!WR && $stable(FRAME_SYNC_SIGNAL))[*4]
        |-> PIN2_OUT == FRAME_SYNC_SIGNAL; endproperty
    a_fs: assert property (p_fs) else $error("frame sync");
endmodule
bind pin_output_mux pin_output_mux_props i_pin_output_mux_props (.*);

// ===== dv/pin_wire_model.sv
// Purpose: far-end view of one pin wire
// Assumes: no pull resistor on the wire
// Notes: released wire shows the inverse of its last level
`timescale 1ns/10ps
module pin_wire_model (
    input CLK,
    input OUT,
    input OE_N,
    output W
);
    reg last_q;
    // inverse when released so a stale level never passes
    always @(posedge CLK) if (!OE_N) last_q <= OUT;
    assign W = OE_N ? ~last_q : OUT;
endmodule

// ===== dv/test_pin_output_mux.sv
// Purpose: register-level regression of the pin output mux
// Assumes: fixed input patterns
// Notes: each pass sweeps all source, secondary and value codes
`timescale 1ns/10ps
module test_pin_output_mux;
    reg CLK = 1'h0, RST_N = 1'h0, WR = 1'h0, RD = 1'h0, FRAME_SYNC_SIGNAL = 1'h0;
    reg [7:0] ADDR = 8'h00, WDATA = 8'h00;
    reg [1:0] PORT_ENABLE = 2'h0, PORT_LOCK = 2'h0, PORT_PASS = 2'h0;
    reg [3:0] PORT0_REMOTE_PIN = 4'h0, PORT1_REMOTE_PIN = 4'h0;
    wire [7:0] RDATA;
    wire PIN1_OUT, PIN1_OE_N, PIN2_OUT, PIN2_OE_N, w1, w2;
    integer failures = 0, checked = 0, i, j;
    always #20 CLK = ~CLK;
    pin_output_mux i_pin_output_mux (.*);
    pin_wire_model i_pin_wire_model_1 (.CLK(CLK), .OUT(PIN1_OUT), .OE_N(PIN1_OE_N), .W(w1));
    pin_wire_model i_pin_wire_model_2 (.CLK(CLK), .OUT(PIN2_OUT), .OE_N(PIN2_OE_N), .W(w2));
    task chk(input [7:0] s, input [7:0] x); begin
        checked = checked + 1;
        if (s !== x) begin
            failures = failures + 1;
            $display("mismatch %0t %h %h", $time, s, x);
        end
    end endtask
    task wr(input [7:0] a, input [7:0] d); begin
        @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'h1};
        @(posedge CLK) WR <= 1'h0;
    end endtask
    task rd(input [7:0] a, input [7:0] x); begin
        @(posedge CLK) {ADDR, RD} <= {a, 1'h1};
        @(posedge CLK) RD <= 1'h0;
        @(negedge CLK) chk(RDATA, x);
    end endtask
    // expected level; an empty port set makes the AND terms low
    function ex(input [2:0] s, input [2:0] c, input v);
        begin
            if (s == 3'h4) ex = c == 3'h0 ? v : c == 3'h1 ? |(PORT_LOCK & PORT_ENABLE)
                : c == 3'h2 ? &(PORT_LOCK | ~PORT_ENABLE) && |PORT_ENABLE
                : c == 3'h3 ? &(PORT_PASS | ~PORT_ENABLE) && |PORT_ENABLE
                : c == 3'h4 && FRAME_SYNC_SIGNAL;
            else if (s > 3'h1) ex = 1'h0;
            else ex = c < 3'h4 ? (s[0] ? PORT1_REMOTE_PIN[c] : PORT0_REMOTE_PIN[c])
                : c == 3'h4 ? PORT_LOCK[s[0]] : c == 3'h5 && PORT_PASS[s[0]];
        end
    endfunction
    task wrap_up; begin
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end endtask
    // main sequence
    initial begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'h1;
        rd(8'h11, 8'h00);
        wr(8'h11, 8'ha5);
        wr(8'h13, 8'hff);
        rd(8'h11, 8'ha5);
        wr(8'h12, 8'h9d);
        rd(8'h12, 8'h9d);
        rd(8'h13, 8'h00);
        $display("register test done");
        for (j = 0; j < 2; j = j + 1) begin
            @(posedge CLK) {PORT_ENABLE, PORT_LOCK, PORT_PASS, PORT0_REMOTE_PIN,
                PORT1_REMOTE_PIN, FRAME_SYNC_SIGNAL} <= j ? 15'h3d4a : 15'h6eb5;
            for (i = 0; i < 128; i = i + 1) begin
                wr(8'h11, {i[6:0], 1'h1} ^ 8'h02);
                wr(8'h12, {i[6:0], 1'h1});
                repeat (4) @(posedge CLK);
                #1 chk(w1, ex(i[3:1], i[6:4], ~i[0]));
                chk(w2, ex(i[3:1], i[6:4], i[0]));
            end
            $display("mux pass done");
        end
        wr(8'h12, 8'h92);
        @(posedge CLK) #1 chk(PIN2_OE_N, 8'h01);
        wrap_up;
    end
endmodule
